/* File: pkg/i2c_clkgen_regs.svh */
// Timing constants and reset values for the serial clock generator
`ifndef I2C_CLKGEN_REGS_SVH
`define I2C_CLKGEN_REGS_SVH

// ----------------------------------------------------------------------
// Clock and divider
// ----------------------------------------------------------------------
`define CORE_CLK_PERIOD_PS      25000
`define PRESCALE_RATIO          8
`define MODULUS_WIDTH           8
`define MODULUS_RESET           8'hFF
`define BYPASS_RESET            1'b0

// ----------------------------------------------------------------------
// Request timing
// ----------------------------------------------------------------------
`define REQ_DROP_MAX_PS         52000
`define REQ_DROP_CYCLES \
    ((`REQ_DROP_MAX_PS / `CORE_CLK_PERIOD_PS) > 0 ? \
     (`REQ_DROP_MAX_PS / `CORE_CLK_PERIOD_PS) : 1)
`define START_MARGIN_CYCLES     1

`endif

/* File: pkg/i2c_clkgen_pkg.sv */
// Types shared by the serial clock generator
package i2c_clkgen_pkg;

    typedef struct packed {
        logic [7:0] clockDividerModulus;
        logic       prescalerBypass;
    } clk_cfg_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_RUN   = 2'b10
    } gen_state_type;

endpackage : i2c_clkgen_pkg

/* File: hw/prescale_divider.sv */
// Fixed divide-by-eight prescaler with bypass
`timescale 1ns/1ps
`include "i2c_clkgen_regs.svh"

module prescale_divider #(
    parameter int RATIO = `PRESCALE_RATIO
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Control
    input  wire logic run,
    input  wire logic bypass,
    // Output enable pulse
    output logic      tick
);

    typedef struct packed {
        logic [2:0] count;
        logic       tick;
    } pre_state_type;

    pre_state_type state_r;
    pre_state_type state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        if (!run)
        begin
            state_nxt.count = 3'h0;
        end
        else if (bypass)
        begin
            state_nxt.tick = 1'b1;
        end
        else if (state_r.count == 3'(RATIO - 1))
        begin
            state_nxt.count = 3'h0;
            state_nxt.tick = 1'b1;
        end
        else
        begin
            state_nxt.count = state_r.count + 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign tick = state_r.tick;

endmodule : prescale_divider

/* File: hw/i2c_serial_clock_generator.sv */
// Serial clock generator and request flow control for the I2C port
`timescale 1ns/1ps
`include "i2c_clkgen_regs.svh"

module i2c_serial_clock_generator #(
    parameter int MOD_W = `MODULUS_WIDTH
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    // Configuration
    input  wire i2c_clkgen_pkg::clk_cfg_type clkCfg,
    input  wire logic                        masterMode,
    input  wire logic                        enable,
    input  wire logic                        slaveBusy,
    // Serial clock pin
    input  wire logic                        sclIn,
    output logic                             sclOut,
    output logic                             sclOe,
    // Host request pins
    input  wire logic                        hostRequestIn,
    output logic                             hostRequestOut,
    output logic                             hostRequestOe
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        i2c_clkgen_pkg::gen_state_type state;
        logic [MOD_W-1:0]              modCount;
        logic                          sclLow;
        logic [1:0]                    sclSync;
        logic [1:0]                    reqSync;
        logic                          sclPrev;
        logic                          reqOut;
        logic                          reqOe;
        logic                          sclOe;
        logic                          sclOut;
        logic                          cfgBypass;
        logic [MOD_W-1:0]              cfgModulus;
    } gen_reg_type;

    gen_reg_type s_r;
    gen_reg_type s_nxt;
    logic        preTick;
    logic        preRun;

    // Terminal count of modulus divider for one half period
    function automatic logic modTerminal(
        input logic [MOD_W-1:0] count,
        input logic [MOD_W-1:0] modulus
    );
        modTerminal = (count == modulus);
    endfunction : modTerminal

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    assign preRun = (s_r.state != i2c_clkgen_pkg::ST_IDLE);

    prescale_divider #(
        .RATIO (`PRESCALE_RATIO)
    ) u_prescale (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .run      (preRun),
        .bypass   (s_r.cfgBypass),
        .tick     (preTick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sclSync = {s_r.sclSync[0], sclIn};
        s_nxt.reqSync = {s_r.reqSync[0], hostRequestIn};
        s_nxt.sclPrev = s_r.sclSync[1];
        case (s_r.state)
            i2c_clkgen_pkg::ST_IDLE:
            begin
                s_nxt.sclOut = 1'b1;
                s_nxt.sclOe = 1'b0;
                s_nxt.sclLow = 1'b0;
                s_nxt.modCount = '0;
                // Full code range accepted
                // Configuration latched only while idle, avoids glitches
                s_nxt.cfgBypass = clkCfg.prescalerBypass;
                s_nxt.cfgModulus = clkCfg.clockDividerModulus;
                if (enable && masterMode && s_r.reqSync[1])
                begin
                    s_nxt.state = i2c_clkgen_pkg::ST_START;
                end
            end
            i2c_clkgen_pkg::ST_START:
            begin
                // First edge after one half period
                if (!enable || !masterMode)
                begin
                    s_nxt.state = i2c_clkgen_pkg::ST_IDLE;
                end
                else if (preTick)
                begin
                    if (modTerminal(s_r.modCount, s_r.cfgModulus))
                    begin
                        s_nxt.modCount = '0;
                        s_nxt.sclOe = 1'b1;
                        s_nxt.sclOut = 1'b0;
                        s_nxt.sclLow = 1'b1;
                        s_nxt.state = i2c_clkgen_pkg::ST_RUN;
                    end
                    else
                    begin
                        s_nxt.modCount = s_r.modCount + MOD_W'(1);
                    end
                end
            end
            i2c_clkgen_pkg::ST_RUN:
            begin
                // Slave mode never keeps driving the clock
                if (!enable || !masterMode)
                begin
                    s_nxt.state = i2c_clkgen_pkg::ST_IDLE;
                end
                // Half period of (modulus+1) prescaled ticks
                // Modulus code n counts n+1 ticks
                else if (preTick)
                begin
                    if (modTerminal(s_r.modCount, s_r.cfgModulus))
                    begin
                        s_nxt.modCount = '0;
                        // Stop after a high phase, no trailing low glitch
                        if (!s_r.sclLow && !s_r.reqSync[1])
                        begin
                            s_nxt.state = i2c_clkgen_pkg::ST_IDLE;
                        end
                        else
                        begin
                            s_nxt.sclLow = !s_r.sclLow;
                            s_nxt.sclOut = s_r.sclLow;
                            s_nxt.sclOe = !s_r.sclLow;
                        end
                    end
                    else
                    begin
                        s_nxt.modCount = s_r.modCount + MOD_W'(1);
                    end
                end
            end
            default:
            begin
                s_nxt.state = i2c_clkgen_pkg::ST_IDLE;
            end
        endcase

        // Slave drops request on each SCL rise
        if (!masterMode && enable)
        begin
            s_nxt.reqOe = 1'b1;
            if (s_r.sclSync[1] && !s_r.sclPrev)
            begin
                s_nxt.reqOut = 1'b0;
            end
            else if (!slaveBusy)
            begin
                s_nxt.reqOut = 1'b1;
            end
        end
        else
        begin
            s_nxt.reqOe = 1'b0;
            s_nxt.reqOut = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '{
                state:      i2c_clkgen_pkg::ST_IDLE,
                modCount:   '0,
                sclLow:     1'b0,
                sclSync:    2'b11,
                reqSync:    2'b00,
                sclPrev:    1'b1,
                reqOut:     1'b1,
                reqOe:      1'b0,
                sclOe:      1'b0,
                sclOut:     1'b1,
                cfgBypass:  `BYPASS_RESET,
                cfgModulus: `MODULUS_RESET
            };
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign sclOut = s_r.sclOut;
    assign sclOe = s_r.sclOe;
    assign hostRequestOut = s_r.reqOut;
    assign hostRequestOe = s_r.reqOe;

endmodule : i2c_serial_clock_generator

/* File: testbench/i2c_clkgen_asserts.sv */
// Port checks for the serial clock generator
`timescale 1ns/1ps
module i2c_clkgen_asserts (
    // Clock and reset
    input wire logic                        core_clk,
    input wire logic                        reset_n,
    // Watched ports
    input wire i2c_clkgen_pkg::clk_cfg_type clkCfg,
    input wire logic                        masterMode,
    input wire logic                        enable,
    input wire logic                        slaveBusy,
    input wire logic                        sclIn,
    input wire logic                        sclOut,
    input wire logic                        sclOe,
    input wire logic                        hostRequestIn,
    input wire logic                        hostRequestOut,
    input wire logic                        hostRequestOe
);
    // ----
    // Phase counter
    // ----
    int   phaseCnt_r;
    logic oePrev_r;
    int   half;
    // Live config: valid because the bench changes it only when idle
    assign half = (int'(clkCfg.clockDividerModulus) + 1)
                * (clkCfg.prescalerBypass ? 1 : 8);
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phaseCnt_r <= 0;
            oePrev_r   <= 1'b0;
        end
        else
        begin
            phaseCnt_r <= (sclOe != oePrev_r) ? 1 : phaseCnt_r + 1;
            oePrev_r   <= sclOe;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence slaveRise;
        $rose(sclIn) && enable && !masterMode;
    endsequence
    slave_req_drop_a: assert property (
        slaveRise |-> ##[1:3] !hostRequestOut)
        else $error("request not dropped after SCL rise");
    busy_hold_a: assert property (
        !hostRequestOut && slaveBusy && enable && !masterMode
        |=> !hostRequestOut) else $error("request rose while busy");
    req_oe_a: assert property (
        (enable && !masterMode) [*2] |-> hostRequestOe)
        else $error("request pin not driven in slave mode");
    master_no_req_a: assert property (
        masterMode [*2] |-> !hostRequestOe)
        else $error("request pin driven in master mode");
    open_drain_a: assert property (
        sclOe |-> !sclOut) else $error("SCL driven high");
    slave_no_drive_a: assert property (
        (!masterMode) [*3] |-> !sclOe) else $error("slave drove SCL");
    idle_release_a: assert property (
        (!enable) [*3] |-> !sclOe) else $error("SCL held while off");
    low_phase_a: assert property (
        $fell(sclOe) && enable |-> phaseCnt_r == half)
        else $error("SCL low phase length wrong");
    high_phase_a: assert property (
        $rose(sclOe) && masterMode |-> phaseCnt_r >= half)
        else $error("SCL high phase too short");
endmodule : i2c_clkgen_asserts

/* File: testbench/i2c_peer_model.sv */
// Far-side peer driving SCL and the request line
`timescale 1ns/1ps
module i2c_peer_model (
    // Clock
    input wire logic core_clk,
    // Peer drives
    output logic     peerSclOe,
    output logic     peerRequest
);
    // ----
    // Peer behaviour
    // ----
    initial
    begin
        peerSclOe   = 1'b0;
        peerRequest = 1'b0;
    end
    // Released SCL floats high by pull-up, so it stands still idle
    task automatic sclPulse(input int half);
        @(posedge core_clk) peerSclOe <= 1'b1;
        repeat (half) @(posedge core_clk);
        peerSclOe <= 1'b0;
        repeat (half) @(posedge core_clk);
    endtask : sclPulse
    task automatic setRequest(input logic v);
        @(posedge core_clk) peerRequest <= v;
    endtask : setRequest
endmodule : i2c_peer_model

/* File: testbench/i2c_serial_clock_generator_bench.sv */
// Self-checking bench for the serial clock generator
`timescale 1ns/1ps
module i2c_serial_clock_generator_bench;
    // ----
    // Signals and instances
    // ----
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    i2c_clkgen_pkg::clk_cfg_type clkCfg = '0;
    logic masterMode = 1'b0;
    logic enable = 1'b0;
    logic slaveBusy = 1'b0;
    logic sclOut, sclOe, hostRequestOut, hostRequestOe;
    logic peerSclOe, peerRequest, sclWire;
    int   errors = 0;
    int   compares = 0;
    always #12.5 core_clk = ~core_clk;
    assign sclWire = (sclOe || peerSclOe) ? 1'b0 : 1'b1;
    i2c_serial_clock_generator dut_u (.core_clk, .reset_n, .clkCfg,
        .masterMode, .enable, .slaveBusy, .sclIn(sclWire), .sclOut,
        .sclOe, .hostRequestIn(peerRequest), .hostRequestOut,
        .hostRequestOe);
    i2c_peer_model peer_u (.core_clk, .peerSclOe, .peerRequest);
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic waitOe(input logic v, output int n);
        n = 0;
        while (sclOe !== v && n < 9000)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask : waitOe
    task automatic masterRun(input logic [7:0] mod, input logic byp);
        int h, n, lo, rises;
        h = (mod + 1) * (byp ? 1 : 8);
        @(posedge core_clk);
        clkCfg <= '{clockDividerModulus: mod, prescalerBypass: byp};
        masterMode <= 1'b1;
        peer_u.setRequest(1'b1);
        waitOe(1'b1, n);
        check("start delay", 1, n >= h && n <= h + 6);
        waitOe(1'b0, lo);
        check("low phase", h, lo);
        waitOe(1'b1, n);
        check("period", 2 * h, lo + n);
        peer_u.setRequest(1'b0);
        // Stop waits for a high phase to end, after the sync delay
        repeat (2 * h + 8) @(negedge core_clk);
        rises = 0;
        repeat (2 * h + 2)
        begin
            @(negedge core_clk);
            rises += (sclOe !== 1'b0);
        end
        check("stopped", 0, rises);
        $display("master run done");
    endtask : masterRun
    task automatic enableDrop;
        int n;
        peer_u.setRequest(1'b1);
        waitOe(1'b1, n);
        @(posedge core_clk) enable <= 1'b0;
        repeat (4) @(negedge core_clk);
        check("released", 0, sclOe);
        peer_u.setRequest(1'b0);
        // Let the withdrawn request clear the synchroniser first
        repeat (4) @(posedge core_clk);
        enable <= 1'b1;
        $display("enable drop done");
    endtask : enableDrop
    task automatic slaveTest;
        @(posedge core_clk) slaveBusy <= 1'b1;
        repeat (3) @(negedge core_clk);
        check("request oe", 1, hostRequestOe);
        check("request ready", 1, hostRequestOut);
        peer_u.sclPulse(6);
        repeat (8) @(negedge core_clk);
        check("request busy", 0, hostRequestOut);
        @(posedge core_clk) slaveBusy <= 1'b0;
        repeat (3) @(negedge core_clk);
        check("request back", 1, hostRequestOut);
        $display("slave test done");
    endtask : slaveTest
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    initial
    begin
        #1500000;
        errors++;
        end_sim();
    end
    initial
    begin
        repeat (8) @(negedge core_clk);
        check("reset drive", 2'b01, {sclOe, sclOut});
        check("reset request", 2'b01, {hostRequestOe, hostRequestOut});
        @(posedge core_clk) reset_n <= 1'b1;
        enable <= 1'b1;
        slaveTest();
        masterRun(8'h02, 1'b1);
        masterRun(8'h00, 1'b1);
        masterRun(8'h04, 1'b1);
        masterRun(8'h00, 1'b0);
        masterRun(8'hFF, 1'b0);
        enableDrop();
        end_sim();
    end
endmodule : i2c_serial_clock_generator_bench
bind i2c_serial_clock_generator i2c_clkgen_asserts chk_u (.core_clk,
    .reset_n, .clkCfg, .masterMode, .enable, .slaveBusy, .sclIn,
    .sclOut, .sclOe, .hostRequestIn, .hostRequestOut, .hostRequestOe);
